// [hdl/beam_state_conditioning.sv]
// Purpose: blanking, smoothing, hold and trigger handling of beam scans
// Assumes: one scan arrives as beams_i with a one-cycle beams_valid_i
// Notes: position results are 1-based beam indices, 0 meaning none found
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// - keep min and max of results during hold
// - interrupted beam stays 0 until hold expires
// - blanking keeps every beam at its index
// - four blanking areas, each contiguous range
// - disabled area passes real beam state
// - fixed area forces its beams 0 or 1
// - copy area takes beam below or above
// - teach maps interrupted runs into areas from area 0 on, one per enabled area
// - teach without interrupted beams clears areas
// - panel auto blanking allows four areas
// - beam mode change drops auto blanked beams
// - power-up teach runs when device is ready
// - successful teach stores differing values
// - failed teach keeps stored teach values
// - interrupted beam counts only in long run
// - smoothing one evaluates every interrupted beam
// - smoothing accepts settings 1 through 255
// - inverted smoothing keeps only long free runs
// - external trigger pulse starts one measurement
// - each device starts after its own delay
// - interfering curtains start at offset times
// - free beam reads 1, interrupted reads 0
// - cascade master triggers continuously by itself
module beam_state_conditioning
   import beam_cond_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [NB-1:0] beams_i,
   input wire logic beams_valid_i,
   input wire logic trig_i,
   input wire logic pu_teach_i,
   output logic [NB-1:0] stream_o,
   output logic meas_start_o,
   output logic trig_o
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic ext_sel;
      logic master;
      logic inv_smooth;
      logic auto_panel;
      logic [1:0] beam_mode;
      logic [7:0] smooth;
      logic [23:0] hold_len;
      logic [23:0] trig_dly;
      logic [23:0] trig_per;
      area_t [AREAS-1:0] areas;
      teach_st_t tst;
      logic teach_ok;
      logic teach_fail;
      logic teach_upd;
      logic started;
      logic [NB-1:0] taught;
      logic [23:0] hold_cnt;
      logic [5:0][7:0] min_res;
      logic [5:0][7:0] max_res;
      logic [NB-1:0] stream;
      logic trig_d;
      logic [23:0] per_cnt;
      logic [23:0] dly_cnt;
      logic dly_act;
      logic meas_start;
      logic trig_out;
   } cond_state_t;

   cond_state_t st_ff;
   cond_state_t nxt_st;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // substitute values for blanked beams; indices never move
   function automatic logic [NB-1:0] apply_blank(
      input logic [NB-1:0] raw,
      input area_t [AREAS-1:0] ar
   );
      logic [NB-1:0] v;
      logic below;
      logic above;
      v = raw;
      below = 1'b1;
      above = 1'b1;
      for (int a = 0; a < AREAS; a++) begin
         if (ar[a].en) begin
            // edge areas have no neighbour, treat it as free
            below = (ar[a].first == 5'h00) ? 1'b1 :
                    raw[ar[a].first - 5'h01];
            above = (ar[a].last == TOP_BEAM) ? 1'b1 :
                    raw[ar[a].last + 5'h01];
            for (int i = 0; i < NB; i++) begin
               if (i >= ar[a].first && i <= ar[a].last) begin
                  unique case (ar[a].mode)
                     BL_ZERO: v[i] = 1'b0;
                     BL_ONE: v[i] = 1'b1;
                     BL_BELOW: v[i] = below;
                     BL_ABOVE: v[i] = above;
                  endcase
               end
            end
         end
      end
      return v;
   endfunction

   // marks set bits that lie in a run of at least len set bits
   function automatic logic [NB-1:0] run_keep(
      input logic [NB-1:0] hit,
      input logic [7:0] len
   );
      logic [NB:0] ext;
      logic [NB-1:0] keep;
      logic [7:0] run;
      ext = {1'b0, hit};
      keep = '0;
      run = 8'h00;
      for (int i = 0; i <= NB; i++) begin
         if (ext[i]) begin
            run = run + 8'h01;
         end else begin
            if (run != 8'h00 && run >= len) begin
               for (int j = 0; j < NB; j++) begin
                  if (j >= i - int'(run) && j < i) begin
                     keep[j] = 1'b1;
                  end
               end
            end
            run = 8'h00;
         end
      end
      return keep;
   endfunction

   // 0 first blocked, 1 last blocked, 2 first clear, 3 last clear,
   // 4 blocked count, 5 clear count
   function automatic logic [5:0][7:0] evaluate(input logic [NB-1:0] v);
      logic [5:0][7:0] r;
      r = '0;
      for (int i = 0; i < NB; i++) begin
         if (!v[i]) begin
            if (r[0] == 8'h00) begin
               r[0] = 8'(i + 1);
            end
            r[1] = 8'(i + 1);
            r[4] = r[4] + 8'h01;
         end else begin
            if (r[2] == 8'h00) begin
               r[2] = 8'(i + 1);
            end
            r[3] = 8'(i + 1);
            r[5] = r[5] + 8'h01;
         end
      end
      return r;
   endfunction

   // finds interrupted runs and turns the first ones into areas
   function automatic auto_res_t auto_map(
      input logic [NB-1:0] raw,
      input logic [2:0] allowed
   );
      auto_res_t res;
      logic [NB:0] ext;
      logic inrun;
      logic [4:0] start;
      res = '0;
      ext = {1'b1, raw};
      inrun = 1'b0;
      start = 5'h00;
      for (int i = 0; i <= NB; i++) begin
         if (!ext[i] && !inrun) begin
            inrun = 1'b1;
            start = 5'(i);
         end else if (ext[i] && inrun) begin
            inrun = 1'b0;
            if (res.runs < 6'(allowed)) begin
               res.ar[res.runs[1:0]] = '{1'b1, BL_ZERO, start,
                                         5'(i - 1)};
            end
            res.runs = res.runs + 6'h01;
         end
      end
      return res;
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic [NB-1:0] blanked;
   logic [NB-1:0] smoothed;
   logic [5:0][7:0] res;
   auto_res_t amap;
   logic [2:0] allowed;
   logic setup;
   logic wr;
   logic bad_addr;
   logic start_src;
   logic int_tick;

   // scan path, all combinational so one scan takes one cycle
   always_comb begin
      blanked = apply_blank(beams_i, st_ff.areas);
      if (st_ff.inv_smooth) begin
         smoothed = run_keep(blanked, st_ff.smooth);
      end else begin
         smoothed = ~run_keep(~blanked, st_ff.smooth);
      end
      res = evaluate(smoothed);
      // panel auto blanking opens all four areas, else as many as are enabled
      allowed = 3'h0;
      for (int a = 0; a < AREAS; a++) begin
         allowed = allowed + {2'b00, st_ff.areas[a].en};
      end
      if (st_ff.auto_panel) begin
         allowed = AUTO_PANEL_AREAS;
      end
      amap = auto_map(beams_i, allowed);
   end

   always_comb begin
      nxt_st = st_ff;
      setup = psel_i && !penable_i;
      wr = psel_i && penable_i && st_ff.pready && pwrite_i &&
           !st_ff.pslverr;
      bad_addr = (paddr_i[1:0] != 2'b00) || (paddr_i > OFS_TAUGHT);
      int_tick = 1'b0;
      start_src = 1'b0;

      // apb: data and answer registered in the setup cycle
      nxt_st.pready = setup;
      nxt_st.pslverr = setup && bad_addr;
      nxt_st.prdata = 32'h00000000;
      if (setup && !bad_addr) begin
         unique case (paddr_i)
            OFS_CTRL: nxt_st.prdata = {24'h000000, st_ff.beam_mode,
               2'b00, st_ff.auto_panel, st_ff.inv_smooth,
               st_ff.master, st_ff.ext_sel};
            OFS_SMOOTH: nxt_st.prdata = {24'h000000, st_ff.smooth};
            OFS_HOLD: nxt_st.prdata = {8'h00, st_ff.hold_len};
            OFS_TDLY: nxt_st.prdata = {8'h00, st_ff.trig_dly};
            OFS_TPER: nxt_st.prdata = {8'h00, st_ff.trig_per};
            OFS_STATUS: nxt_st.prdata = {28'h0000000, st_ff.teach_upd,
               st_ff.teach_fail, st_ff.teach_ok, st_ff.tst};
            OFS_MIN_IDX: nxt_st.prdata = st_ff.min_res[3:0];
            OFS_MAX_IDX: nxt_st.prdata = st_ff.max_res[3:0];
            OFS_MIN_CNT: nxt_st.prdata = {16'h0000, st_ff.min_res[5:4]};
            OFS_MAX_CNT: nxt_st.prdata = {16'h0000, st_ff.max_res[5:4]};
            OFS_STREAM: nxt_st.prdata = st_ff.stream;
            OFS_TAUGHT: nxt_st.prdata = st_ff.taught;
            default: begin
               for (int a = 0; a < AREAS; a++) begin
                  if (paddr_i == OFS_AREA0 + 8'(4 * a)) begin
                     nxt_st.prdata = {11'h000, st_ff.areas[a].last,
                        3'h0, st_ff.areas[a].first, 5'h00,
                        st_ff.areas[a].mode, st_ff.areas[a].en};
                  end
               end
            end
         endcase
      end

      // register writes, taken at the access edge only
      if (wr) begin
         unique case (paddr_i)
            OFS_CTRL: begin
               nxt_st.ext_sel = pwdata_i[C_EXT];
               nxt_st.master = pwdata_i[C_MASTER];
               nxt_st.inv_smooth = pwdata_i[C_INV];
               nxt_st.auto_panel = pwdata_i[C_AUTO];
               nxt_st.beam_mode = pwdata_i[C_MODE_LO+1:C_MODE_LO];
               // beam numbering shifts with the mode, old areas are void under panel auto blanking
               if (st_ff.auto_panel &&
                   pwdata_i[C_MODE_LO+1:C_MODE_LO] != st_ff.beam_mode) begin
                  for (int a = 0; a < AREAS; a++) begin
                     nxt_st.areas[a].en = 1'b0;
                  end
               end
               if (pwdata_i[C_TEACH]) begin
                  nxt_st.tst = T_WAIT;
               end
            end
            OFS_SMOOTH: begin
               // zero is no legal run length and is ignored
               if (pwdata_i[7:0] != 8'h00) begin
                  nxt_st.smooth = pwdata_i[7:0];
               end
            end
            OFS_HOLD: nxt_st.hold_len = pwdata_i[23:0];
            OFS_TDLY: nxt_st.trig_dly = pwdata_i[23:0];
            OFS_TPER: nxt_st.trig_per = pwdata_i[23:0];
            default: begin
               for (int a = 0; a < AREAS; a++) begin
                  if (paddr_i == OFS_AREA0 + 8'(4 * a)) begin
                     nxt_st.areas[a] = '{pwdata_i[0],
                        blank_mode_t'(pwdata_i[2:1]),
                        pwdata_i[12:8], pwdata_i[20:16]};
                  end
               end
            end
         endcase
      end

      // strap caught on the first cycle after reset release
      if (!st_ff.started) begin
         nxt_st.started = 1'b1;
         if (pu_teach_i) begin
            nxt_st.tst = T_WAIT;
         end
      end

      // teach on the next complete scan
      unique case (st_ff.tst)
         T_IDLE: begin
         end
         T_WAIT: begin
            if (beams_valid_i) begin
               nxt_st.tst = T_IDLE;
               nxt_st.teach_upd = 1'b0;
               if (allowed != 3'h0) begin
                  nxt_st.areas = amap.ar;
                  nxt_st.teach_ok = amap.runs <= 6'(allowed);
               end else begin
                  // an object in the field fails the teach
                  nxt_st.teach_ok = &blanked;
               end
               nxt_st.teach_fail = !nxt_st.teach_ok;
               if (nxt_st.teach_ok &&
                   apply_blank(beams_i, nxt_st.areas) != st_ff.taught) begin
                  nxt_st.taught = apply_blank(beams_i, nxt_st.areas);
                  nxt_st.teach_upd = 1'b1;
               end
            end
         end
      endcase

      // hold: extremes and stream merge until the period runs out
      if (st_ff.hold_cnt != CNT_RST) begin
         nxt_st.hold_cnt = st_ff.hold_cnt - 24'h000001;
      end
      if (beams_valid_i) begin
         if (st_ff.hold_cnt == CNT_RST) begin
            nxt_st.min_res = res;
            nxt_st.max_res = res;
            nxt_st.stream = smoothed;
            nxt_st.hold_cnt = st_ff.hold_len;
         end else begin
            for (int k = 0; k < 6; k++) begin
               if (res[k] < st_ff.min_res[k]) begin
                  nxt_st.min_res[k] = res[k];
               end
               if (res[k] > st_ff.max_res[k]) begin
                  nxt_st.max_res[k] = res[k];
               end
            end
            nxt_st.stream = st_ff.stream & smoothed;
         end
      end

      // internal trigger period, master drives it out
      if (st_ff.per_cnt == CNT_RST) begin
         int_tick = 1'b1;
         nxt_st.per_cnt = st_ff.trig_per;
      end else begin
         nxt_st.per_cnt = st_ff.per_cnt - 24'h000001;
      end
      nxt_st.trig_out = int_tick && st_ff.master;
      nxt_st.trig_d = trig_i;
      if (st_ff.ext_sel) begin
         start_src = trig_i && !st_ff.trig_d;
      end else begin
         start_src = int_tick;
      end

      // per-device delay staggers cascaded curtains
      nxt_st.meas_start = 1'b0;
      if (start_src) begin
         nxt_st.dly_cnt = st_ff.trig_dly;
         nxt_st.dly_act = 1'b1;
      end else if (st_ff.dly_act) begin
         if (st_ff.dly_cnt == CNT_RST) begin
            nxt_st.meas_start = 1'b1;
            nxt_st.dly_act = 1'b0;
         end else begin
            nxt_st.dly_cnt = st_ff.dly_cnt - 24'h000001;
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         st_ff <= '0;
         st_ff.smooth <= SMOOTH_RST;
         st_ff.stream <= '1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata_o = st_ff.prdata;
   assign pready_o = st_ff.pready;
   assign pslverr_o = st_ff.pslverr;
   assign stream_o = st_ff.stream;
   assign meas_start_o = st_ff.meas_start;
   assign trig_o = st_ff.trig_out;
endmodule

// [hdl/beam_cond_pkg.sv]
// Purpose: shared constants and types for the beam conditioning block
// Assumes: 32 beams per scan, APB register access with 32-bit data
// Notes: beam state 1 means free, 0 means interrupted
package beam_cond_pkg;
   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int NB = 32;
   localparam int AREAS = 4;
   localparam logic [4:0] TOP_BEAM = 5'h1f;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SMOOTH = 8'h04;
   localparam logic [7:0] OFS_HOLD = 8'h08;
   localparam logic [7:0] OFS_TDLY = 8'h0c;
   localparam logic [7:0] OFS_TPER = 8'h10;
   localparam logic [7:0] OFS_AREA0 = 8'h14;
   localparam logic [7:0] OFS_AREA3 = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_MIN_IDX = 8'h28;
   localparam logic [7:0] OFS_MAX_IDX = 8'h2c;
   localparam logic [7:0] OFS_MIN_CNT = 8'h30;
   localparam logic [7:0] OFS_MAX_CNT = 8'h34;
   localparam logic [7:0] OFS_STREAM = 8'h38;
   localparam logic [7:0] OFS_TAUGHT = 8'h3c;
   // ---------------------------------------------------------------
   // control fields and reset values
   // ---------------------------------------------------------------
   localparam int C_EXT = 0;
   localparam int C_MASTER = 1;
   localparam int C_INV = 2;
   localparam int C_AUTO = 3;
   localparam int C_TEACH = 5;
   localparam int C_MODE_LO = 6;
   localparam logic [7:0] SMOOTH_RST = 8'h01;
   localparam logic [23:0] CNT_RST = 24'h000000;
   localparam logic [2:0] AUTO_PANEL_AREAS = 3'h4;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      BL_ZERO = 2'b00,
      BL_ONE = 2'b01,
      BL_BELOW = 2'b10,
      BL_ABOVE = 2'b11
   } blank_mode_t;
   typedef enum logic {
      T_IDLE = 1'b0,
      T_WAIT = 1'b1
   } teach_st_t;
   // area register: [0] enable, [2:1] mode, [12:8] first, [20:16] last
   typedef struct packed {
      logic en;
      blank_mode_t mode;
      logic [4:0] first;
      logic [4:0] last;
   } area_t;
   typedef struct packed {
      area_t [AREAS-1:0] ar;
      logic [5:0] runs;
   } auto_res_t;
endpackage

// [testbench/plc_trigger_model.sv]
// Purpose: controller model issuing trigger pulses on request
// Assumes: trigger line is driven low between pulses
// Notes: LEAD sets how slowly the controller answers
`timescale 1ns/1ns
module plc_trigger_model #(
   parameter int LEAD = 1,
   parameter int WIDTH = 2
) (
   input wire logic clk_i,
   input wire logic fire_i,
   output logic trig_o
);
   int cnt = 0;
   initial trig_o = 1'b0;
   // one pulse per request, same line feeds every curtain
   // requests inside a pulse are dropped, so pulses stay apart
   always @(posedge clk_i) begin
      if (fire_i && cnt == 0) begin
         cnt <= LEAD + WIDTH;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
      trig_o <= cnt != 0 && cnt <= WIDTH;
   end
endmodule

// [testbench/beam_cond_sva.sv]
// Purpose: port checks for the beam conditioning block
// Assumes: one clock, synchronous active-low reset
// Notes: shadows ctrl, hold and delay from accepted writes
`timescale 1ns/1ns
module beam_cond_sva
   import beam_cond_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [NB-1:0] beams_i,
   input wire logic beams_valid_i,
   input wire logic trig_i,
   input wire logic pu_teach_i,
   input wire logic [NB-1:0] stream_o,
   input wire logic meas_start_o,
   input wire logic trig_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // ---------------------------------------------
   // shadow state
   // ---------------------------------------------
   logic wr_ok, ext_q, master_q, trig_q;
   logic [23:0] hold_q, tdly_q, hcnt_q;
   logic [25:0] wait_q;
   assign wr_ok = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
   // refused writes never reach the shadows
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         {ext_q, master_q, trig_q} <= 3'h0;
         {hold_q, tdly_q, hcnt_q} <= '0;
         wait_q <= '0;
      end else begin
         trig_q <= trig_i;
         if (wr_ok && paddr_i == OFS_CTRL) begin
            ext_q <= pwdata_i[C_EXT];
            master_q <= pwdata_i[C_MASTER];
         end
         if (wr_ok && paddr_i == OFS_HOLD) hold_q <= pwdata_i[23:0];
         if (wr_ok && paddr_i == OFS_TDLY) tdly_q <= pwdata_i[23:0];
         if (beams_valid_i && hcnt_q == '0) hcnt_q <= hold_q;
         else if (hcnt_q != '0) hcnt_q <= hcnt_q - 24'h1;
         // a fresh edge restarts the delay
         if (ext_q && trig_i && !trig_q) wait_q <= {2'h0, tdly_q} + 26'h2;
         else if (wait_q != '0) wait_q <= wait_q - 26'h1;
      end
   end
   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   a_ready_next: assert property (psel_i && !penable_i |=> pready_o)
      else $error("ready late");
   a_ready_once: assert property (pready_o |=> !pready_o)
      else $error("ready too long");
   a_err_refused: assert property (psel_i && !penable_i &&
      (paddr_i > 8'h3c || paddr_i[1:0] != 2'h0)
      |=> pslverr_o && prdata_o == '0) else $error("bad address taken");
   a_start_single: assert property (
      meas_start_o |=> !meas_start_o) else $error("start too long");
   a_start_delay: assert property (
      wait_q == 26'h1 |-> meas_start_o) else $error("late start");
   a_ext_quiet: assert property (
      ext_q && $past(ext_q, 6) && wait_q == '0 && $past(wait_q) == '0
      |-> !meas_start_o) else $error("start without trigger");
   a_stream_stands: assert property (
      !beams_valid_i |=> $stable(stream_o)) else $error("stream moved");
   a_hold_merge: assert property (
      beams_valid_i && hcnt_q > 24'h1
      |=> (stream_o & ~$past(stream_o)) == '0) else $error("hold lost");
   a_master_only: assert property (
      !master_q && !$past(master_q) && !$past(master_q, 2) |-> !trig_o)
      else $error("trigger while slave");
   c_hold: cover property (beams_valid_i && hcnt_q > 24'h1);
   c_delay: cover property (wait_q == 26'h1 && meas_start_o);
   c_refused: cover property (pready_o && pslverr_o);
   c_master: cover property (master_q && trig_o);
endmodule
bind beam_state_conditioning beam_cond_sva u_beam_cond_sva (
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .beams_i(beams_i), .trig_i(trig_i),
   .beams_valid_i(beams_valid_i), .pu_teach_i(pu_teach_i),
   .stream_o(stream_o), .meas_start_o(meas_start_o), .trig_o(trig_o));

// [testbench/beam_state_conditioning_tb_top.sv]
// Purpose: self-checking bench for beam_state_conditioning
// Assumes: APB answer within 16 cycles
// Notes: small counter values keep the run short
`timescale 1ns/1ns
module beam_state_conditioning_tb_top import beam_cond_pkg::*;;
   logic ref_clk_i, rst_b_i, psel_i, penable_i, pwrite_i, last_err;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic pready_o, pslverr_o, beams_valid_i, trig_i, pu_teach_i;
   logic [NB-1:0] beams_i, stream_o;
   logic meas_start_o, trig_o, fire;
   int fails, checks_done;
   beam_state_conditioning u_beam_state_conditioning (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .beams_i(beams_i), .trig_i(trig_i),
      .beams_valid_i(beams_valid_i), .pu_teach_i(pu_teach_i),
      .stream_o(stream_o), .meas_start_o(meas_start_o), .trig_o(trig_o));
   plc_trigger_model u_plc_trigger_model (.clk_i(ref_clk_i),
      .fire_i(fire), .trig_o(trig_i));
   always #10 ref_clk_i = ~ref_clk_i;
   // ---------------------------------------------
   // bus and compare helpers
   // ---------------------------------------------
   task automatic end_sim();
      if (fails == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   // request held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge ref_clk_i);
      {psel_i, penable_i, pwrite_i} <= {2'b10, w};
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i) penable_i <= 1'b1;
      for (n = 0; pready_o !== 1'b1 && n < 16; n++) @(negedge ref_clk_i);
      if (n >= 16) begin
         fails++;
         end_sim();
      end
      q = prdata_o;
      last_err = pslverr_o;
      @(posedge ref_clk_i) {psel_i, penable_i} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m = '1);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk($sformatf("reg %h", a), e & m, q & m);
   endtask
   // stream lands at the valid edge, read one edge later
   task automatic scan(input logic [31:0] b);
      @(posedge ref_clk_i) beams_valid_i <= 1'b1;
      beams_i <= b;
      @(posedge ref_clk_i) beams_valid_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic scan_chk(input logic [31:0] b, input logic [31:0] e);
      scan(b);
      chk("stream", e, stream_o);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic regs();
      chk("reset stream", 32'hffff_ffff, stream_o);
      rd(OFS_SMOOTH, {24'h0, SMOOTH_RST}, 32'hff);
      rd(OFS_HOLD, {8'h0, CNT_RST}, 32'hff_ffff);
      rd(8'h40, 32'h0);
      chk("error", 32'h1, {31'h0, last_err});
      wr(OFS_SMOOTH, 32'hff);
      wr(OFS_SMOOTH, 32'h0);
      rd(OFS_SMOOTH, 32'hff, 32'hff);
   endtask
   task automatic smoothing();
      wr(OFS_SMOOTH, 32'h3);
      scan_chk(32'hffff_f8f9, 32'hffff_f8ff);
      wr(OFS_CTRL, 32'h4);
      scan_chk(32'hffff_f8f9, 32'hffff_f8f8);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_SMOOTH, 32'h1);
      scan_chk(32'hffff_f8f9, 32'hffff_f8f9);
   endtask
   // each area in turn over beams 4..6, one mode per area
   task automatic blanking();
      logic [7:0] raw [4] = '{8'h2f, 8'ha7, 8'h2f, 8'ha7};
      logic [7:0] exp [4] = '{8'h0f, 8'hf7, 8'h7f, 8'hf7};
      logic [7:0] a;
      for (int i = 0; i < 4; i++) begin
         a = OFS_AREA0 + 8'(4 * i);
         wr(a, 32'h0006_0401 | 32'(2 * i));
         scan_chk({24'hff_ffff, raw[i]}, {24'hff_ffff, exp[i]});
         wr(a, 32'h0006_0400);
         scan_chk(32'hffff_ff2f, 32'hffff_ff2f);
      end
   endtask
   task automatic hold();
      wr(OFS_HOLD, 32'ha);
      scan(32'hffff_fffe);
      scan_chk(32'hffff_ffff, 32'hffff_fffe);
      rd(OFS_MAX_CNT, 32'h2001, 32'hffff);
      repeat (12) @(posedge ref_clk_i);
      scan_chk(32'hffff_ffff, 32'hffff_ffff);
      rd(OFS_MAX_CNT, 32'h2000, 32'hffff);
      wr(OFS_HOLD, 32'h0);
   endtask
   task automatic trig_delay();
      int k;
      wr(OFS_CTRL, 32'h1);
      wr(OFS_TDLY, 32'h3);
      @(posedge ref_clk_i) fire <= 1'b1;
      @(posedge ref_clk_i) fire <= 1'b0;
      for (k = 0; trig_i !== 1'b1 && k < 50; k++) @(negedge ref_clk_i);
      for (k = 0; meas_start_o !== 1'b1 && k < 50; k++) @(negedge ref_clk_i);
      chk("start delay", 32'd5, k);
   endtask
   task automatic master_tick();
      int n = 0;
      wr(OFS_TPER, 32'h4);
      wr(OFS_CTRL, 32'h2);
      repeat (3) @(posedge ref_clk_i);
      repeat (20) @(negedge ref_clk_i) n += int'(trig_o === 1'b1);
      chk("trigger count", 32'd4, n);
   endtask
   task automatic teach();
      logic [31:0] t;
      wr(OFS_CTRL, 32'h28);
      scan(32'hff8f_ef3b);
      rd(OFS_AREA0, 32'h0002_0201);
      rd(OFS_AREA3, 32'h0016_1401);
      rd(OFS_STATUS, 32'h2, 32'h7);
      wr(OFS_CTRL, 32'h48);
      rd(OFS_AREA3, 32'h0, 32'h1);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_AREA0 + 8'h4, 32'h3);
      wr(OFS_CTRL, 32'h20);
      scan(32'hffff_f8ff);
      rd(OFS_AREA0, 32'h000a_0801);
      rd(OFS_AREA0 + 8'h4, 32'h0);
      wr(OFS_CTRL, 32'h20);
      scan(32'hffff_ffff);
      rd(OFS_AREA0, 32'h0);
      wr(OFS_AREA0, 32'h1);
      apb(1'b0, OFS_TAUGHT, 32'h0, t);
      wr(OFS_CTRL, 32'h20);
      scan(32'hffff_f8f9);
      rd(OFS_STATUS, 32'h4, 32'h7);
      rd(OFS_TAUGHT, t);
   endtask
   // second reset in mid-run with the strap set
   task automatic pu_teach();
      rst_b_i <= 1'b0;
      pu_teach_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      @(posedge ref_clk_i) pu_teach_i <= 1'b0;
      scan(32'hffff_ffff);
      rd(OFS_STATUS, 32'ha, 32'hf);
   endtask
   initial begin
      {ref_clk_i, rst_b_i, psel_i, penable_i, pwrite_i} = 5'h0;
      {beams_valid_i, pu_teach_i, fire, last_err} = 4'h0;
      {paddr_i, pwdata_i} = '0;
      beams_i = '1;
      {fails, checks_done} = '0;
      repeat (4) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      regs();
      smoothing();
      blanking();
      hold();
      trig_delay();
      master_tick();
      teach();
      pu_teach();
      end_sim();
   end
endmodule
